// ==== hw/fblp_defines.vh ====
// Purpose: Constants for the flash block-lock protection host controller.
// Assumes: 100 MHz clock, x8 multiplexed command/address/data flash bus.
// Notes:   Rules carried by the host and checked by the bench follow.
`ifndef FBLP_DEFINES_VH
`define FBLP_DEFINES_VH

`define FBLP_CMD_LOCK_ALL    8'h2A
`define FBLP_CMD_UNLOCK_SET  8'h23
`define FBLP_CMD_UNLOCK_CNF  8'h24
`define FBLP_CMD_LOCK_DOWN   8'h2C
`define FBLP_CMD_STATUS      8'h7A

`define FBLP_OP_LOCK_ALL     3'h0
`define FBLP_OP_UNLOCK       3'h1
`define FBLP_OP_LOCK_DOWN    3'h2
`define FBLP_OP_STATUS       3'h3
`define FBLP_OP_GUARD        3'h4

`define FBLP_BLK_LSB         18
`define FBLP_BLK_W           12
`define FBLP_ROW_LSB         12

`define FBLP_CLK_NS          10
`define FBLP_GUARD_NS        100
`define FBLP_GUARD_CYC       ((`FBLP_GUARD_NS + `FBLP_CLK_NS - 1) / `FBLP_CLK_NS)
`define FBLP_PHASE_CYC       2
`define FBLP_READ_CYC        3

`define FBLP_ST_LOCKED       3'b010
`define FBLP_ST_UNLOCKED     3'b110
`define FBLP_ST_LOCKDOWN     3'b001
`define FBLP_ST_UNL_IN_LD    3'b101

`endif

// ==== hw/fblp_cycle.v ====
// Purpose: One bus write or read cycle on the flash command/address/data pins.
// Assumes: Strobes are active low; caller holds inputs stable while busy.
// Notes:   Each cycle is a low phase then a high phase of PHASE cycles each.
`timescale 1ns/1ps
`include "fblp_defines.vh"
module fblp_cycle #(
   parameter PHASE = `FBLP_PHASE_CYC
) (
   input  wire       clk_i,      // System clock.
   input  wire       srst_i,     // Synchronous reset, active high.
   input  wire       start_i,    // Start one bus cycle, pulse.
   input  wire       rd_i,       // 1 read cycle, 0 write cycle.
   input  wire       cle_i,      // Command latch level for this cycle.
   input  wire       ale_i,      // Address latch level for this cycle.
   input  wire [7:0] dout_i,     // Byte to write.
   input  wire [7:0] din_i,      // Synchronised data pins.
   output wire       busy_o,     // Cycle in progress.
   output reg        done_o,     // Cycle finished, pulse.
   output reg  [7:0] rdata_o,    // Byte sampled in a read cycle.
   output reg        cle_o,      // Command latch enable pin.
   output reg        ale_o,      // Address latch enable pin.
   output reg        we_n_o,     // Write strobe pin, active low.
   output reg        re_n_o,     // Read strobe pin, active low.
   output reg  [7:0] dq_o,       // Data pin output value.
   output reg        dq_oe_o     // Data pin output enable.
);
   reg [1:0] phase_ff;
   reg [7:0] cnt_ff;
   reg       rd_ff;

   assign busy_o = (phase_ff != 2'd0);

   always @(posedge clk_i) begin
      done_o <= 1'b0;
      if (srst_i) begin
         phase_ff <= 2'd0;
         cnt_ff   <= 8'h00;
         rd_ff    <= 1'b0;
         rdata_o  <= 8'h00;
         cle_o    <= 1'b0;
         ale_o    <= 1'b0;
         we_n_o   <= 1'b1;
         re_n_o   <= 1'b1;
         dq_o     <= 8'h00;
         dq_oe_o  <= 1'b0;
      end else begin
         case (phase_ff)
            2'd0: begin
               if (start_i) begin
                  phase_ff <= 2'd1;
                  cnt_ff   <= PHASE[7:0];
                  rd_ff    <= rd_i;
                  cle_o    <= cle_i;
                  ale_o    <= ale_i;
                  we_n_o   <= rd_i;
                  re_n_o   <= ~rd_i;
                  dq_o     <= dout_i;
                  dq_oe_o  <= ~rd_i;
               end
            end
            2'd1: begin
               cnt_ff <= cnt_ff - 8'h01;
               if (cnt_ff == 8'h01) begin
                  phase_ff <= 2'd2;
                  cnt_ff   <= PHASE[7:0];
                  we_n_o <= 1'b1;
                  re_n_o <= 1'b1;
               end
            end
            2'd2: begin
               cnt_ff <= cnt_ff - 8'h01;
               // Pin data reach din_i two clocks late, so a read samples PHASE+2 clocks after the strobe fell.
               // This needs PHASE of at least 2.
               if (rd_ff && cnt_ff == PHASE[7:0] - 8'h01) begin
                  rdata_o <= din_i;
               end
               if (cnt_ff == 8'h01) begin
                  phase_ff <= 2'd0;
                  done_o   <= 1'b1;
                  cle_o    <= 1'b0;
                  ale_o    <= 1'b0;
                  dq_oe_o  <= 1'b0;
               end
            end
            default: begin
               phase_ff <= 2'd0;
            end
         endcase
      end
   end
endmodule

// ==== hw/fblp_host.v ====
// Purpose: Host controller issuing block-lock commands to a parallel flash.
// Assumes: One clock; device pins ready_busy_n and data are asynchronous.
// Notes:   One operation at a time; req_i is taken only while ready_o is high.
`timescale 1ns/1ps
`include "fblp_defines.vh"
module fblp_host #(
   parameter PHASE     = `FBLP_PHASE_CYC,
   parameter GUARD_CYC = `FBLP_GUARD_CYC
) (
   input  wire        clk_i,                  // System clock, 100 MHz.
   input  wire        srst_i,                 // Synchronous reset, active high.
   input  wire        req_i,                  // Operation request, pulse.
   input  wire [2:0]  op_i,                   // Operation code.
   input  wire [11:0] start_blk_i,            // Start block, or queried block.
   input  wire [11:0] end_blk_i,              // End block of an unlock range.
   output wire        ready_o,                // Idle, request may be given.
   output reg         done_o,                 // Operation finished, pulse.
   output reg         err_o,                  // Operation refused, with done_o.
   output reg  [2:0]  status_o,               // Lock status read back.
   output reg         status_vld_o,           // status_o holds a fresh value.
   output reg         lock_feature_select_o,  // Lock-feature select pin.
   output reg         wp_n_o,                 // Write-guard pin, active low.
   output reg         ce_n_o,                 // Chip enable pin, active low.
   output wire        cle_o,                  // Command latch enable pin.
   output wire        ale_o,                  // Address latch enable pin.
   output wire        we_n_o,                 // Write strobe pin, active low.
   output wire        re_n_o,                 // Read strobe pin, active low.
   output wire [7:0]  dq_o,                   // Data pins, output value.
   output wire        dq_oe_o,                // Data pins, output enable.
   input  wire [7:0]  dq_i,                   // Data pins, input value.
   input  wire        ready_busy_n_i          // Device ready, low while busy.
);
   //------------------------------------------------------------------
   // Pin synchronisers.
   //------------------------------------------------------------------
   reg [7:0] dq_s1_ff;
   reg [7:0] dq_s2_ff;
   reg       rb_s1_ff;
   reg       rb_s2_ff;

   always @(posedge clk_i) begin
      if (srst_i) begin
         dq_s1_ff <= 8'h00;
         dq_s2_ff <= 8'h00;
         rb_s1_ff <= 1'b1;
         rb_s2_ff <= 1'b1;
      end else begin
         dq_s1_ff <= dq_i;
         dq_s2_ff <= dq_s1_ff;
         rb_s1_ff <= ready_busy_n_i;
         rb_s2_ff <= rb_s1_ff;
      end
   end

   //------------------------------------------------------------------
   // Sequencer.
   //------------------------------------------------------------------
   localparam S_IDLE  = 3'd0;
   localparam S_CMD   = 3'd1;
   localparam S_ADDR  = 3'd2;
   localparam S_CNF   = 3'd3;
   localparam S_ADDR2 = 3'd4;
   localparam S_READ  = 3'd5;
   localparam S_GUARD = 3'd6;
   localparam S_END   = 3'd7;
   localparam READ_CYC = `FBLP_READ_CYC;

   reg  [2:0]  state_ff;
   reg  [2:0]  op_ff;
   reg  [11:0] sblk_ff;
   reg  [11:0] eblk_ff;
   reg  [1:0]  idx_ff;
   reg  [7:0]  gcnt_ff;
   reg         issued_ff;

   reg         cyc_start;
   reg         cyc_rd;
   reg         cyc_cle;
   reg         cyc_ale;
   reg  [7:0]  cyc_dout;
   reg  [11:0] cur_blk;
   reg  [29:0] row_addr;
   wire        cyc_busy;
   wire        cyc_done;
   wire [7:0]  cyc_rdata;

   assign ready_o = (state_ff == S_IDLE);

   // Block number placed on A18..A29 of the three address cycles, low first.
   always @* begin
      cur_blk  = (state_ff == S_ADDR2) ? eblk_ff : sblk_ff;
      row_addr = 30'd0;
      row_addr[`FBLP_BLK_LSB +: `FBLP_BLK_W] = cur_blk;
   end

   always @* begin
      cyc_start = 1'b0;
      cyc_rd    = 1'b0;
      cyc_cle   = 1'b0;
      cyc_ale   = 1'b0;
      cyc_dout  = 8'h00;
      if (!cyc_busy && !cyc_done && !issued_ff) begin
         case (state_ff)
            S_CMD: begin
               cyc_start = 1'b1;
               cyc_cle   = 1'b1;
               case (op_ff)
                  `FBLP_OP_LOCK_ALL:  cyc_dout = `FBLP_CMD_LOCK_ALL;
                  `FBLP_OP_UNLOCK:    cyc_dout = `FBLP_CMD_UNLOCK_SET;
                  `FBLP_OP_LOCK_DOWN: cyc_dout = `FBLP_CMD_LOCK_DOWN;
                  default:            cyc_dout = `FBLP_CMD_STATUS;
               endcase
            end
            S_CNF: begin
               cyc_start = 1'b1;
               cyc_cle   = 1'b1;
               cyc_dout  = `FBLP_CMD_UNLOCK_CNF;
            end
            S_ADDR, S_ADDR2: begin
               cyc_start = 1'b1;
               cyc_ale   = 1'b1;
               case (idx_ff)
                  2'd0:    cyc_dout = row_addr[`FBLP_ROW_LSB +: 8];
                  2'd1:    cyc_dout = row_addr[`FBLP_ROW_LSB + 8 +: 8];
                  default: cyc_dout = {6'd0, row_addr[`FBLP_ROW_LSB + 16 +: 2]};
               endcase
            end
            S_READ: begin
               cyc_start = 1'b1;
               cyc_rd    = 1'b1;
            end
            default: begin
               cyc_start = 1'b0;
            end
         endcase
      end
   end

   always @(posedge clk_i) begin
      done_o <= 1'b0;
      if (srst_i) begin
         state_ff              <= S_IDLE;
         op_ff                 <= 3'd0;
         sblk_ff               <= 12'h000;
         eblk_ff               <= 12'h000;
         idx_ff                <= 2'd0;
         gcnt_ff               <= 8'h00;
         issued_ff             <= 1'b0;
         err_o                 <= 1'b0;
         status_o              <= 3'd0;
         status_vld_o          <= 1'b0;
         lock_feature_select_o <= 1'b0;
         wp_n_o                <= 1'b1;
         ce_n_o                <= 1'b1;
      end else begin
         issued_ff <= cyc_start;
         case (state_ff)
            S_IDLE: begin
               ce_n_o <= 1'b1;
               if (req_i) begin
                  op_ff   <= op_i;
                  sblk_ff <= start_blk_i;
                  eblk_ff <= end_blk_i;
                  idx_ff  <= 2'd0;
                  err_o   <= 1'b0;
                  lock_feature_select_o <= 1'b1;
                  if (op_i == `FBLP_OP_GUARD) begin
                     wp_n_o   <= 1'b0;
                     gcnt_ff  <= GUARD_CYC[7:0];
                     state_ff <= S_GUARD;
                  end else if (op_i > `FBLP_OP_GUARD ||
                               (op_i == `FBLP_OP_UNLOCK && start_blk_i > end_blk_i) ||
                               (op_i == `FBLP_OP_STATUS && !rb_s2_ff)) begin
                     err_o    <= 1'b1;
                     state_ff <= S_END;
                  end else begin
                     ce_n_o   <= 1'b0;
                     state_ff <= S_CMD;
                  end
               end
            end
            S_CMD: begin
               if (cyc_done) begin
                  if (op_ff == `FBLP_OP_UNLOCK || op_ff == `FBLP_OP_STATUS) begin
                     state_ff <= S_ADDR;
                  end else begin
                     state_ff <= S_END;
                  end
                  if (op_ff != `FBLP_OP_STATUS) begin
                     status_vld_o <= 1'b0;
                  end
               end
            end
            S_ADDR, S_ADDR2: begin
               if (cyc_done) begin
                  idx_ff <= idx_ff + 2'd1;
                  if (idx_ff == 2'd2) begin
                     idx_ff <= 2'd0;
                     if (state_ff == S_ADDR2) begin
                        state_ff <= S_END;
                     end else if (op_ff == `FBLP_OP_UNLOCK) begin
                        state_ff <= S_CNF;
                     end else begin
                        gcnt_ff  <= READ_CYC[7:0];
                        state_ff <= S_GUARD;
                     end
                  end
               end
            end
            S_CNF: begin
               if (cyc_done) begin
                  state_ff <= S_ADDR2;
               end
            end
            S_READ: begin
               if (cyc_done) begin
                  status_o     <= cyc_rdata[2:0];
                  status_vld_o <= 1'b1;
                  state_ff     <= S_END;
               end
            end
            S_GUARD: begin
               gcnt_ff <= gcnt_ff - 8'h01;
               if (gcnt_ff == 8'h01) begin
                  if (op_ff == `FBLP_OP_STATUS) begin
                     state_ff <= S_READ;
                  end else begin
                     wp_n_o   <= 1'b1;
                     state_ff <= S_END;
                  end
               end
            end
            S_END: begin
               ce_n_o   <= 1'b1;
               done_o   <= 1'b1;
               state_ff <= S_IDLE;
            end
            default: begin
               state_ff <= S_IDLE;
            end
         endcase
      end
   end

   fblp_cycle #(
      .PHASE (PHASE)
   ) u_cycle (
      .clk_i   (clk_i),
      .srst_i  (srst_i),
      .start_i (cyc_start),
      .rd_i    (cyc_rd),
      .cle_i   (cyc_cle),
      .ale_i   (cyc_ale),
      .dout_i  (cyc_dout),
      .din_i   (dq_s2_ff),
      .busy_o  (cyc_busy),
      .done_o  (cyc_done),
      .rdata_o (cyc_rdata),
      .cle_o   (cle_o),
      .ale_o   (ale_o),
      .we_n_o  (we_n_o),
      .re_n_o  (re_n_o),
      .dq_o    (dq_o),
      .dq_oe_o (dq_oe_o)
   );
endmodule

// ==== sim/fblp_host_sva.sv ====
// Purpose: Assertion checker for the block-lock host controller.
// Assumes: Default bus-cycle phase of 2 clocks.
// Notes:   Bound to fblp_host at the foot of this file.
`timescale 1ns/1ps
`include "fblp_defines.vh"
module fblp_host_sva #(
   parameter GUARD_CYC = 10
) (
   input wire        clk_i,                 // Clock.
   input wire        srst_i,                // Reset.
   input wire        req_i,                 // Request.
   input wire [2:0]  op_i,                  // Operation.
   input wire [11:0] start_blk_i,           // Start block.
   input wire [11:0] end_blk_i,             // End block.
   input wire        ready_o,               // Idle.
   input wire        done_o,                // Done pulse.
   input wire        err_o,                 // Refused.
   input wire        lock_feature_select_o, // Select pin.
   input wire        wp_n_o,                // Guard pin.
   input wire        ce_n_o,                // Chip enable.
   input wire        cle_o,                 // Command latch.
   input wire        ale_o,                 // Address latch.
   input wire        we_n_o,                // Write strobe.
   input wire        re_n_o,                // Read strobe.
   input wire [7:0]  dq_o,                  // Data out.
   input wire        dq_oe_o                // Data enable.
);
   // -----------------------------------------------------------------
   // Guard pulse length counter and properties
   // -----------------------------------------------------------------
   reg  [7:0] wlow_ff;
   wire       take = req_i && ready_o;
   wire       bad = (op_i > 3'h4) || (op_i == 3'h1 && start_blk_i > end_blk_i);
   always @(posedge clk_i) begin
      if (srst_i || wp_n_o) begin
         wlow_ff <= 8'h00;
      end else if (wlow_ff != 8'hFF) begin
         wlow_ff <= wlow_ff + 8'h01;
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (srst_i);
   AST_SEL_HIGH: assert property (!ce_n_o |-> lock_feature_select_o) else $error("select low in bus cycle");
   AST_GUARD_LEN: assert property ($rose(wp_n_o) |-> wlow_ff >= GUARD_CYC) else $error("guard pulse short");
   AST_REFUSE: assert property (take && bad |=> ce_n_o ##1 (ce_n_o && done_o && err_o)) else $error("refusal");
   AST_WE_CE: assert property (!we_n_o |-> !ce_n_o && dq_oe_o && (cle_o ^ ale_o)) else $error("write frame");
   AST_WE_LEN: assert property ($fell(we_n_o) |=> !we_n_o ##1 we_n_o) else $error("write strobe length");
   AST_RD_FREE: assert property (!re_n_o |-> !dq_oe_o && !ce_n_o && !we_n_o == 1'b0) else $error("read frame");
   AST_LOCKALL: assert property (take && op_i == 3'h0 |-> ##2 (cle_o && !we_n_o && dq_o == `FBLP_CMD_LOCK_ALL)
      ##6 done_o) else $error("lock-all walk");
   AST_READY: assert property (take |=> !ready_o) else $error("ready after take");
   AST_DONE: assert property (done_o |=> !done_o) else $error("done not a pulse");
   COV_GUARD: cover property ($rose(wp_n_o));
   COV_ERR: cover property (done_o && err_o);
   COV_READ: cover property ($fell(re_n_o));
endmodule

bind fblp_host fblp_host_sva #(.GUARD_CYC(GUARD_CYC)) u_sva (.clk_i(clk_i), .srst_i(srst_i), .req_i(req_i),
   .op_i(op_i), .start_blk_i(start_blk_i), .end_blk_i(end_blk_i), .ready_o(ready_o), .done_o(done_o),
   .err_o(err_o), .lock_feature_select_o(lock_feature_select_o), .wp_n_o(wp_n_o), .ce_n_o(ce_n_o),
   .cle_o(cle_o), .ale_o(ale_o), .we_n_o(we_n_o), .re_n_o(re_n_o), .dq_o(dq_o), .dq_oe_o(dq_oe_o));

// ==== sim/fblp_flash_model.sv ====
// Purpose: Behavioural flash device holding block-lock state.
// Assumes: Commands and addresses latch on the write strobe rising edge.
// Notes:   Released data pins show the inverse of the last status byte.
`timescale 1ns/1ps
`include "fblp_defines.vh"
module fblp_flash_model (
   input  wire       sel_i,    // Lock select.
   input  wire       wp_n_i,   // Guard pin.
   input  wire       ce_n_i,   // Chip enable.
   input  wire       cle_i,    // Command latch.
   input  wire       ale_i,    // Address latch.
   input  wire       we_n_i,   // Write strobe.
   input  wire       re_n_i,   // Read strobe.
   input  wire [7:0] dq_i,     // Bus level.
   input  wire       busy_i,   // Force busy.
   output wire [7:0] dq_o,     // Data out.
   output wire       rb_n_o    // Ready.
);
   reg [11:0] lo_ff = 12'h000, hi_ff = 12'h000, sblk_ff = 12'h000, qblk_ff = 12'h000;
   reg [7:0]  cmd_ff = 8'h00, b0_ff = 8'h00, b1_ff = 8'h00, last_ff = 8'h00;
   reg [1:0]  acnt_ff = 2'h0;
   reg        unl_ff = 1'b0, ld_ff = 1'b0, stm_ff = 1'b0;
   realtime   tlow;
   wire [11:0] blk = {dq_i[1:0], b1_ff, b0_ff[7:6]};
   wire inr = unl_ff && qblk_ff >= lo_ff && qblk_ff <= hi_ff;
   wire [2:0] st = inr ? (ld_ff ? 3'b101 : 3'b110) : (ld_ff ? 3'b001 : 3'b010);
   assign dq_o = (stm_ff && !ce_n_i && !re_n_i) ? {5'h0D, st} : ~last_ff;
   assign rb_n_o = !busy_i;
   always @(negedge re_n_i) last_ff <= {5'h0D, st};
   always @(negedge wp_n_i) begin
      unl_ff = 1'b0;
      tlow = $realtime;
   end
   always @(posedge wp_n_i) if ($realtime - tlow >= 100.0) ld_ff = 1'b0;
   always @(posedge we_n_i) if (!ce_n_i) begin
      if (cle_i) begin
         cmd_ff = dq_i;
         acnt_ff = 2'h0;
         stm_ff = 1'b0;
         if (sel_i && dq_i == `FBLP_CMD_LOCK_ALL) unl_ff = 1'b0;
         if (sel_i && dq_i == `FBLP_CMD_LOCK_DOWN) ld_ff = 1'b1;
      end else if (ale_i) begin
         if (acnt_ff == 2'h0) b0_ff = dq_i;
         if (acnt_ff == 2'h1) b1_ff = dq_i;
         if (acnt_ff == 2'h2 && cmd_ff == `FBLP_CMD_UNLOCK_SET) sblk_ff = blk;
         if (acnt_ff == 2'h2 && cmd_ff == `FBLP_CMD_UNLOCK_CNF && sel_i && !ld_ff) begin
            lo_ff = sblk_ff;
            hi_ff = blk;
            unl_ff = 1'b1;
         end
         if (acnt_ff == 2'h2 && cmd_ff == `FBLP_CMD_STATUS && sel_i && !busy_i) begin
            qblk_ff = blk;
            stm_ff = 1'b1;
         end
         acnt_ff = acnt_ff + 2'h1;
      end
   end
endmodule

// ==== sim/fblp_host_bench.sv ====
// Purpose: Self-checking bench for the block-lock host controller.
// Assumes: Default parameters; inputs change 1 ns after the clock edge.
// Notes:   Expected lock states come from an integer range model.
`timescale 1ns/1ps
module fblp_host_bench;
   reg         clk_i = 1'b0, srst_i = 1'b1, req_i = 1'b0, busy = 1'b0;
   reg  [2:0]  op_i = 3'h0;
   reg  [11:0] sb = 12'h000, eb = 12'h000;
   wire        ready, done, err, vld, sel, wp_n, ce_n, cle, ale, we_n, re_n, dq_oe, rb_n;
   wire [2:0]  st;
   wire [7:0]  h_dq, m_dq;
   wire [7:0]  bus = dq_oe ? h_dq : m_dq;
   integer     error_cnt = 0, n_tests = 0, lo = 0, hi = 0, unl = 0, ld = 0, i, a, b;
   always #5 clk_i = ~clk_i;
   fblp_host u_dut (.clk_i(clk_i), .srst_i(srst_i), .req_i(req_i), .op_i(op_i), .start_blk_i(sb),
      .end_blk_i(eb), .ready_o(ready), .done_o(done), .err_o(err), .status_o(st), .status_vld_o(vld),
      .lock_feature_select_o(sel), .wp_n_o(wp_n), .ce_n_o(ce_n), .cle_o(cle), .ale_o(ale), .we_n_o(we_n),
      .re_n_o(re_n), .dq_o(h_dq), .dq_oe_o(dq_oe), .dq_i(bus), .ready_busy_n_i(rb_n));
   fblp_flash_model u_flash (.sel_i(sel), .wp_n_i(wp_n), .ce_n_i(ce_n), .cle_i(cle), .ale_i(ale), .we_n_i(we_n),
      .re_n_i(re_n), .dq_i(bus), .busy_i(busy), .dq_o(m_dq), .rb_n_o(rb_n));
   // -----------------------------------------------------------------
   // Tasks
   // -----------------------------------------------------------------
   task report_and_stop;
      begin
         if (error_cnt == 0 && n_tests > 0)
            $display("TEST PASSED");
         else
            $display("TEST FAILED");
         $finish;
      end
   endtask
   task chk(input [7:0] got, input [7:0] exp);
      begin
         n_tests = n_tests + 1;
         if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   function [7:0] exp_st(input integer blk);
      if (unl != 0 && blk >= lo && blk <= hi)
         exp_st = (ld != 0) ? 8'h05 : 8'h06;
      else
         exp_st = (ld != 0) ? 8'h01 : 8'h02;
   endfunction
   task run(input [2:0] op, input integer s, input integer e);
      integer k;
      begin
         k = 0;
         while (ready !== 1'b1 && k < 50) begin
            @(posedge clk_i);
            #1 k = k + 1;
         end
         if (ready !== 1'b1) begin
            error_cnt = error_cnt + 1;
            report_and_stop;
         end
         @(posedge clk_i);
         #1 req_i = 1'b1;
         op_i = op;
         sb = s[11:0];
         eb = e[11:0];
         @(posedge clk_i);
         #1 req_i = 1'b0;
         k = 0;
         while (done !== 1'b1 && k < 200) begin
            @(posedge clk_i);
            #1 k = k + 1;
         end
         if (done !== 1'b1) begin
            error_cnt = error_cnt + 1;
            report_and_stop;
         end
      end
   endtask
   task probe(input integer blk);
      begin
         run(3'h3, blk, 0);
         chk({7'h00, err}, 8'h00);
         chk({5'h00, st}, exp_st(blk));
         chk({7'h00, vld}, 8'h01);
      end
   endtask
   // -----------------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------------
   initial begin
      a = $urandom(46);
      repeat (5) @(posedge clk_i);
      #1 srst_i = 1'b0;
      probe($urandom % 4096);
      for (i = 0; i < 4; i = i + 1) begin
         a = 1 + $urandom % 4000;
         b = (i == 0) ? a : a + $urandom % 8;
         run(3'h1, a, b);
         lo = a;
         hi = b;
         unl = 1;
         probe(a);
         probe(b);
         probe(a - 1);
         probe(b + 1);
      end
      run(3'h2, 0, 0);
      ld = 1;
      probe(lo);
      probe(hi + 1);
      run(3'h1, 4050, 4060);
      probe(4055);
      run(3'h4, 0, 0);
      ld = 0;
      unl = 0;
      probe(lo);
      run(3'h1, 100, 100);
      run(3'h0, 0, 0);
      chk({7'h00, vld}, 8'h00);
      probe(100);
      for (i = 5; i < 8; i = i + 1) begin
         run(i[2:0], 0, 0);
         chk({7'h00, err}, 8'h01);
      end
      run(3'h1, 9, 3);
      chk({7'h00, err}, 8'h01);
      probe(9);
      busy = 1'b1;
      repeat (4) @(posedge clk_i);
      run(3'h3, 100, 0);
      chk({7'h00, err}, 8'h01);
      busy = 1'b0;
      repeat (3) @(posedge clk_i);
      probe(100);
      report_and_stop;
   end
endmodule
